// file: dv/mii_phy_side_interface_bench.sv
// Self-checking bench for the PHY and MAC ends of the MII link
`timescale 1ns/1ps
module mii_phy_side_interface_bench;
  import mps_pkg::*;
  logic        clk_in, reset_in, speed_100_in, full_duplex_in, heartbeat_en_in;
  logic        rx_valid_in, rx_code_err_in, rx_ready_out, line_tx_valid_out;
  logic        line_tx_halt_out, line_speed_100_out, line_full_duplex_out;
  logic        mgmt_wr_out, tx_valid_in, tx_err_in, tx_taken_out, rx_valid_out;
  logic        rx_err_out, crs_out, col_out, mgmt_go_in, mgmt_read_in;
  logic        mgmt_busy_out, mgmt_done_out, ptx;
  logic [3:0]  rx_data_in, line_tx_data_out, tx_data_in, rx_data_out;
  logic [9:0]  mgmt_addr_out, mgmt_addr_in;
  logic [15:0] mgmt_wr_data_out, mgmt_rd_data_in, mgmt_wdata_in, mgmt_rdata_out;
  logic [25:0] tq[$], rq[$], mq[$];
  logic [31:0] rnd = 32'h8046;
  int          errors = 0, checks_done = 0, ncol = 0, ncrs = 0, c0, c1;
  logic [2:0]  modes [5] = '{3'h1, 3'h0, 3'h3, 3'h5, 3'h7};
  mps_link_if link ();
  mps_phy_end i_mps_phy_end (.*);
  mps_mac_end i_mps_mac_end (.*);
  mps_link_props i_mps_link_props (.clk_in(clk_in), .reset_in(reset_in),
    .tx_clk(link.tx_clk), .txd(link.txd), .tx_en(link.tx_en),
    .tx_er(link.tx_er), .rx_clk(link.rx_clk), .rxd(link.rxd),
    .rx_dv(link.rx_dv), .rx_er(link.rx_er), .crs(link.crs), .mdc(link.mdc),
    .mdio_phy_o(link.mdio_phy_o), .mdio_mac_o(link.mdio_mac_o),
    .mdio_phy_oe(link.mdio_phy_oe), .mdio_mac_oe(link.mdio_mac_oe));
  ////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [25:0] pop(ref logic [25:0] q[$]);
    return (q.size() > 0) ? q.pop_front() : 'x;
  endfunction : pop
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic check(input logic [25:0] seen, input logic [25:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic bound(input int n);
    if (n >= 3000) begin
      errors++;
      $display("unexpected at %0t: wait ran out", $time);
      final_report();
    end
  endtask : bound
  // Offer nibbles to the MAC end, reloading on each taken pulse
  task automatic send_tx(input int cnt);
    int n;
    for (int i = 0; i < cnt; i++) begin
      rnd = lfsr(rnd);
      tx_valid_in <= 1'b1;
      tx_data_in <= rnd[3:0];
      tx_err_in <= rnd[4];
      tq.push_back((speed_100_in && rnd[4]) ? 26'h10 : 26'(rnd[3:0]));
      n = 0;
      do @(posedge clk_in); while (!tx_taken_out && ++n < 3000);
      bound(n);
    end
    tx_valid_in <= 1'b0;
  endtask : send_tx
  // Push receive words into the PHY queue, holding each until ready
  task automatic send_rx(input int cnt);
    int n;
    for (int i = 0; i < cnt; i++) begin
      rnd = lfsr(rnd);
      rx_valid_in <= 1'b1;
      rx_data_in <= rnd[3:0];
      rx_code_err_in <= rnd[5];
      rq.push_back(26'({speed_100_in & rnd[5], rnd[3:0]}));
      n = 0;
      do @(posedge clk_in); while (!rx_ready_out && ++n < 3000);
      bound(n);
    end
    rx_valid_in <= 1'b0;
  endtask : send_rx
  // One management frame from the MAC end
  task automatic mgmt(input logic r, input logic [9:0] a, input logic [15:0] d);
    int n;
    mgmt_read_in <= r;
    mgmt_addr_in <= a;
    mgmt_wdata_in <= r ? ~d : d;
    mgmt_rd_data_in <= d;
    mgmt_go_in <= 1'b1;
    mq.push_back({a, d});
    @(posedge clk_in);
    mgmt_go_in <= 1'b0;
    @(posedge clk_in);
    check(26'(mgmt_busy_out), 26'h1);
    n = 0;
    do @(posedge clk_in); while (!mgmt_done_out && ++n < 3000);
    bound(n);
  endtask : mgmt
  ////////////////////////////////////////
  // Clock generator
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  // Scoreboard: each result against the oldest note
  always @(posedge clk_in) begin
    ptx <= link.tx_clk;
    ncol <= ncol + int'(col_out);
    ncrs <= ncrs + int'(crs_out);
    if (link.tx_clk && !ptx && line_tx_valid_out)
      check({line_tx_halt_out, line_tx_data_out}, pop(tq));
    if (rx_valid_out)
      check({rx_err_out, rx_data_out}, pop(rq));
    if (mgmt_wr_out)
      check({mgmt_addr_out, mgmt_wr_data_out}, pop(mq));
    if (mgmt_done_out && mgmt_read_in)
      check({mgmt_addr_out, mgmt_rdata_out}, pop(mq));
  end
  // Main sequence over all speed and duplex modes
  initial begin
    {speed_100_in, full_duplex_in, heartbeat_en_in, rx_valid_in, rx_data_in,
     rx_code_err_in, tx_valid_in, tx_data_in, tx_err_in, mgmt_go_in,
     mgmt_read_in, mgmt_addr_in, mgmt_wdata_in, mgmt_rd_data_in} = '0;
    reset_in = 1'b1;
    repeat (12) @(posedge clk_in);
    reset_in <= 1'b0;
    for (int m = 0; m < 5; m++) begin
      {speed_100_in, full_duplex_in, heartbeat_en_in} <= modes[m];
      repeat (40) @(posedge clk_in);
      check(26'({line_speed_100_out, line_full_duplex_out}),
            26'({speed_100_in, full_duplex_in}));
      c0 = ncol;
      c1 = ncrs;
      send_tx(8);
      repeat (120) @(posedge clk_in);
      check(26'(ncol - c0), (modes[m] == 3'h1) ? 26'(SQE_CYC) : 26'h0);
      check(26'(ncrs != c1), 26'(!full_duplex_in));
      c0 = ncol;
      fork
        send_tx(8);
        send_rx(8);
      join
      repeat (200) @(posedge clk_in);
      check(26'(ncol != c0), 26'(!full_duplex_in));
      $display("mode %b done", modes[m]);
    end
    rnd = lfsr(rnd);
    mgmt(1'b0, 10'h2A5, rnd[15:0]);
    rnd = lfsr(rnd);
    mgmt(1'b1, 10'h15A, rnd[15:0]);
    repeat (20) @(posedge clk_in);
    check(26'(tq.size() + rq.size() + mq.size()), 26'h0);
    $display("management test done");
    final_report();
  end
endmodule : mii_phy_side_interface_bench

// file: dv/mps_link_props.sv
// Concurrent checks on the MII link signals between the two ends
`timescale 1ns/1ps
module mps_link_props (
  input  wire logic       clk_in,
  input  wire logic       reset_in,
  input  wire logic       tx_clk,
  input  wire logic [3:0] txd,
  input  wire logic       tx_en,
  input  wire logic       tx_er,
  input  wire logic       rx_clk,
  input  wire logic [3:0] rxd,
  input  wire logic       rx_dv,
  input  wire logic       rx_er,
  input  wire logic       crs,
  input  wire logic       mdc,
  input  wire logic       mdio_phy_o,
  input  wire logic       mdio_mac_o,
  input  wire logic       mdio_phy_oe,
  input  wire logic       mdio_mac_oe
);
  import mps_pkg::*;
  logic [4:0] run_reg;
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  ////////////////////////////////////////
  // Cycles spent at the present transmit clock level
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) run_reg <= 5'h01;
    else if ($changed(tx_clk)) run_reg <= 5'h01;
    else run_reg <= run_reg + 5'h01;
  end
  ////////////////////////////////////////
  // Clock, data and management line checks
  tx_clk_half_a: assert property ($fell(tx_clk) |->
    run_reg == HALF_100 || run_reg == HALF_10) else $error("bad tx_clk");
  rx_clk_same_a: assert property (rx_clk == tx_clk)
    else $error("rx_clk differs from tx_clk");
  rxd_on_fall_a: assert property ($changed(rxd) |-> $fell(rx_clk))
    else $error("rxd moved off the falling edge");
  rx_dv_fall_a: assert property ($changed(rx_dv) |-> $fell(rx_clk))
    else $error("rx_dv moved off the falling edge");
  rx_er_frame_a: assert property (rx_er |-> rx_dv)
    else $error("rx_er outside a packet");
  tx_load_time_a: assert property ($changed({txd, tx_en, tx_er}) |->
    $past(tx_clk) && !$past(tx_clk, 2)) else $error("txd moved late");
  crs_from_rx_a: assert property (rx_dv |=> crs)
    else $error("crs missing during receive");
  mdc_high_time_a: assert property ($rose(mdc) |-> mdc[*4] ##1 !mdc)
    else $error("mdc high time off");
  mdio_pull_only_a: assert property (!mdio_phy_o && !mdio_mac_o)
    else $error("mdio driven high");
  mdio_one_driver_a: assert property (!(mdio_phy_oe && mdio_mac_oe))
    else $error("both ends pull mdio");
endmodule : mps_link_props

// file: verilog/mps_link_if.sv
// MII link between the PHY end and the MAC end
`timescale 1ns/1ps
interface mps_link_if;
  logic       tx_clk;
  logic [3:0] txd;
  logic       tx_en;
  logic       tx_er;
  logic       rx_clk;
  logic [3:0] rxd;
  logic       rx_dv;
  logic       rx_er;
  logic       crs;
  logic       col;
  logic       mdc;
  logic       mdio_phy_o;
  logic       mdio_phy_oe;
  logic       mdio_mac_o;
  logic       mdio_mac_oe;
  logic       mdio;

  // Open-drain line with pull-up: low while either end pulls it down
  assign mdio = !((mdio_phy_oe && !mdio_phy_o) ||
                  (mdio_mac_oe && !mdio_mac_o));

  modport phy (
    output tx_clk, rx_clk, rxd, rx_dv, rx_er, crs, col,
    output mdio_phy_o, mdio_phy_oe,
    input  txd, tx_en, tx_er, mdc, mdio
  );
  modport mac (
    input  tx_clk, rx_clk, rxd, rx_dv, rx_er, crs, col,
    output txd, tx_en, tx_er, mdc, mdio_mac_o, mdio_mac_oe,
    input  mdio
  );
endinterface : mps_link_if

// file: verilog/mps_mac_end.sv
// MAC end of the MII link with its management master
`timescale 1ns/1ps
module mps_mac_end (
  input  wire logic                          clk_in,
  input  wire logic                          reset_in,
  mps_link_if.mac                            link,
  input  wire logic                          tx_valid_in,
  input  wire logic [mps_pkg::NIB_W-1:0]     tx_data_in,
  input  wire logic                          tx_err_in,
  output logic                               tx_taken_out,
  output logic                               rx_valid_out,
  output logic      [mps_pkg::NIB_W-1:0]     rx_data_out,
  output logic                               rx_err_out,
  output logic                               crs_out,
  output logic                               col_out,
  input  wire logic                          mgmt_go_in,
  input  wire logic                          mgmt_read_in,
  input  wire logic [mps_pkg::MD_ADDR_W-1:0] mgmt_addr_in,
  input  wire logic [mps_pkg::MD_DATA_W-1:0] mgmt_wdata_in,
  output logic                               mgmt_busy_out,
  output logic                               mgmt_done_out,
  output logic      [mps_pkg::MD_DATA_W-1:0] mgmt_rdata_out
);
  import mps_pkg::*;

  logic             tx_clk_d_reg;
  logic             rx_clk_d_reg;
  logic             tx_rise;
  logic             rx_rise;
  logic [NIB_W-1:0] txd_reg;
  logic             tx_en_reg;
  logic             tx_er_reg;
  mps_mm_state_e    mm_state_reg;
  logic [63:0]      frame_reg;
  logic             rd_reg;
  logic [5:0]       bit_reg;
  logic [2:0]       mdc_div_reg;
  logic             mdc_reg;
  logic [1:0]       mdio_sync_reg;

  ////////////////////////////////////////////////////////////////////////
  // Data path

  assign tx_rise = link.tx_clk && !tx_clk_d_reg;
  assign rx_rise = link.rx_clk && !rx_clk_d_reg;

  // Edge history of the MII clocks
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_clk_d_reg <= 1'b0;
      rx_clk_d_reg <= 1'b0;
    end else begin
      tx_clk_d_reg <= link.tx_clk;
      rx_clk_d_reg <= link.rx_clk;
    end
  end

  // Next nibble launched after each rising transmit clock
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      txd_reg      <= '0;
      tx_en_reg    <= 1'b0;
      tx_er_reg    <= 1'b0;
      tx_taken_out <= 1'b0;
    end else begin
      tx_taken_out <= 1'b0;
      if (tx_rise) begin
        txd_reg      <= tx_valid_in ? tx_data_in : '0;
        tx_en_reg    <= tx_valid_in;
        tx_er_reg    <= tx_valid_in && tx_err_in;
        tx_taken_out <= tx_valid_in;
      end
    end
  end

  assign link.txd   = txd_reg;
  assign link.tx_en = tx_en_reg;
  assign link.tx_er = tx_er_reg;

  // Receive nibbles taken at the rising receive clock
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rx_valid_out <= 1'b0;
      rx_data_out  <= '0;
      rx_err_out   <= 1'b0;
      crs_out      <= 1'b0;
      col_out      <= 1'b0;
    end else begin
      crs_out      <= link.crs;
      col_out      <= link.col;
      rx_valid_out <= rx_rise && link.rx_dv;
      if (rx_rise) begin
        rx_data_out <= link.rxd;
        rx_err_out  <= link.rx_dv && link.rx_er;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Management master

  // Line level through two flip-flops
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mdio_sync_reg <= 2'h3;
    end else begin
      mdio_sync_reg <= {mdio_sync_reg[0], link.mdio};
    end
  end

  // Bits change on falling MDC, are sampled on rising MDC
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mm_state_reg   <= MM_IDLE;
      frame_reg      <= '0;
      rd_reg         <= 1'b0;
      bit_reg        <= 6'h00;
      mdc_div_reg    <= 3'h0;
      mdc_reg        <= 1'b0;
      mgmt_busy_out  <= 1'b0;
      mgmt_done_out  <= 1'b0;
      mgmt_rdata_out <= '0;
    end else begin
      mgmt_done_out <= 1'b0;
      case (mm_state_reg)
        MM_IDLE: begin
          if (mgmt_go_in) begin
            mm_state_reg  <= MM_SHIFT;
            mgmt_busy_out <= 1'b1;
            rd_reg        <= mgmt_read_in;
            frame_reg     <= {MD_PREAMBLE, MD_START,
                              mgmt_read_in ? OP_RD : OP_WR, mgmt_addr_in,
                              mgmt_read_in ? TA_RD : TA_WR,
                              mgmt_read_in ? 16'hFFFF : mgmt_wdata_in};
            bit_reg       <= 6'h00;
            mdc_div_reg   <= 3'h0;
            mdc_reg       <= 1'b0;
          end
        end
        MM_SHIFT: begin
          mdc_div_reg <= mdc_div_reg + 3'h1;
          if (mdc_div_reg == MDC_HALF - 3'h1) begin
            mdc_div_reg <= 3'h0;
            mdc_reg     <= !mdc_reg;
            if (!mdc_reg) begin
              if (rd_reg && bit_reg >= MD_DATA_1ST) begin
                mgmt_rdata_out <= {mgmt_rdata_out[MD_DATA_W-2:0],
                                   mdio_sync_reg[1]};
              end
            end else if (bit_reg == MD_LAST_BIT) begin
              // Ends on the fall after the last rise, so the PHY sees it
              mm_state_reg  <= MM_IDLE;
              mgmt_busy_out <= 1'b0;
              mgmt_done_out <= 1'b1;
              frame_reg     <= {64{1'b1}};
            end else begin
              bit_reg   <= bit_reg + 6'h01;
              frame_reg <= {frame_reg[62:0], 1'b1};
            end
          end
        end
        default: begin
          mm_state_reg <= MM_IDLE;
        end
      endcase
    end
  end

  assign link.mdc         = mdc_reg;
  assign link.mdio_mac_o  = 1'b0;
  assign link.mdio_mac_oe = !frame_reg[63];
endmodule : mps_mac_end

// file: verilog/mps_phy_end.sv
// PHY end of the MII link with its receive queue
`timescale 1ns/1ps
module mps_fifo #(
  parameter int WIDTH = 5,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_in,
  input  wire logic             reset_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic      [WIDTH-1:0] out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW:0]      count_next;
  logic             push;
  logic             pop;

  assign push = in_valid_in && in_ready_out;
  assign pop  = out_valid_out && out_ready_in;
  assign out_data_out = mem_reg[rd_ptr_reg];

  // Occupancy after this cycle
  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + (AW + 1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (AW + 1)'(1);
    end
  end

  // Pointers, count and registered flags
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_ptr_reg    <= '0;
      rd_ptr_reg    <= '0;
      count_reg     <= '0;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + AW'(1);
      if (pop) rd_ptr_reg <= rd_ptr_reg + AW'(1);
      count_reg     <= count_next;
      in_ready_out  <= count_next != FULL;
      out_valid_out <= count_next != '0;
    end
  end

  // Storage
  always_ff @(posedge clk_in) begin
    if (push) mem_reg[wr_ptr_reg] <= in_data_in;
  end
endmodule : mps_fifo

////////////////////////////////////////////////////////////////////////////
// Function
// - Management clock at most 25 MHz
// - Management interface runs from management clock
// - MDIO open drain: pull low or release
// - Half duplex carrier from receive or transmit
// - Full duplex carrier from receive only
// - Half duplex collision on simultaneous activity
// - 10M half heartbeat: collision 1 us after transmit
// - Full duplex: no collision, no heartbeat
// - Transmit clock 25 or 2.5 MHz
// - MAC nibbles synchronous to transmit clock
// - Transmit data valid only with enable
// - 100M transmit error substitutes halt symbol
// - Receive clock 25 or 2.5 MHz
// - Receive data changes on falling edge
// - Receive valid with nibbles, falling edge
// - 100M receive error on invalid code
// - Line speed follows forced or negotiated mode
module mps_phy_end (
  input  wire logic                          clk_in,
  input  wire logic                          reset_in,
  mps_link_if.phy                            link,
  input  wire logic                          speed_100_in,
  input  wire logic                          full_duplex_in,
  input  wire logic                          heartbeat_en_in,
  input  wire logic                          rx_valid_in,
  input  wire logic [mps_pkg::NIB_W-1:0]     rx_data_in,
  input  wire logic                          rx_code_err_in,
  output logic                               rx_ready_out,
  output logic      [mps_pkg::NIB_W-1:0]     line_tx_data_out,
  output logic                               line_tx_valid_out,
  output logic                               line_tx_halt_out,
  output logic                               line_speed_100_out,
  output logic                               line_full_duplex_out,
  output logic      [mps_pkg::MD_ADDR_W-1:0] mgmt_addr_out,
  output logic                               mgmt_wr_out,
  output logic      [mps_pkg::MD_DATA_W-1:0] mgmt_wr_data_out,
  input  wire logic [mps_pkg::MD_DATA_W-1:0] mgmt_rd_data_in
);
  import mps_pkg::*;

  logic [4:0]           div_reg;
  logic                 lclk_reg;
  logic [4:0]           half;
  logic                 tick;
  logic                 rise;
  logic                 fall;
  logic                 tx_act_reg;
  logic [5:0]           sqe_cnt_reg;
  logic                 crs_reg;
  logic                 col_reg;
  logic [NIB_W-1:0]     rxd_reg;
  logic                 rx_dv_reg;
  logic                 rx_er_reg;
  logic                 q_valid;
  logic [RXQ_W-1:0]     q_data;
  logic [2:0]           mdc_sync_reg;
  logic [1:0]           mdio_sync_reg;
  logic                 md_rise;
  logic                 md_bit;
  mps_md_state_e        md_state_reg;
  logic [4:0]           md_cnt_reg;
  logic [12:0]          md_head_reg;
  logic [MD_DATA_W-1:0] md_shift_reg;
  logic                 md_oe_reg;

  ////////////////////////////////////////////////////////////////////////
  // Clock generation

  // Mode is taken at a clock edge of a quiet link: no frame or half cut
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      line_speed_100_out   <= 1'b0;
      line_full_duplex_out <= 1'b0;
    end else if (tick && !tx_act_reg && !rx_dv_reg && !link.tx_en) begin
      line_speed_100_out   <= speed_100_in;
      line_full_duplex_out <= full_duplex_in;
    end
  end

  assign half = line_speed_100_out ? HALF_100 : HALF_10;
  assign tick = div_reg >= half - 5'h01;
  assign rise = tick && !lclk_reg;
  assign fall = tick && lclk_reg;

  // Divider from the reference; both MII clocks share it
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      div_reg  <= 5'h00;
      lclk_reg <= 1'b0;
    end else if (tick) begin
      div_reg  <= 5'h00;
      lclk_reg <= !lclk_reg;
    end else begin
      div_reg  <= div_reg + 5'h01;
    end
  end

  assign link.tx_clk = lclk_reg;
  assign link.rx_clk = lclk_reg;

  ////////////////////////////////////////////////////////////////////////
  // Transmit path

  // Nibbles are taken at the rising transmit clock edge
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      tx_act_reg        <= 1'b0;
      line_tx_valid_out <= 1'b0;
      line_tx_data_out  <= '0;
      line_tx_halt_out  <= 1'b0;
    end else if (rise) begin
      tx_act_reg        <= link.tx_en;
      line_tx_valid_out <= link.tx_en;
      line_tx_data_out  <= (link.tx_en && !(link.tx_er &&
                           line_speed_100_out)) ? link.txd : '0;
      line_tx_halt_out  <= link.tx_en && link.tx_er &&
                           line_speed_100_out;
    end
  end

  // Heartbeat timer armed at the end of each 10M half duplex frame
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sqe_cnt_reg <= 6'h00;
    end else if (line_full_duplex_out) begin
      sqe_cnt_reg <= 6'h00;
    end else if (rise && tx_act_reg && !link.tx_en &&
                 !line_speed_100_out && heartbeat_en_in) begin
      sqe_cnt_reg <= SQE_CYC;
    end else if (sqe_cnt_reg != 6'h00) begin
      sqe_cnt_reg <= sqe_cnt_reg - 6'h01;
    end
  end

  // Carrier sense and collision
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      crs_reg <= 1'b0;
      col_reg <= 1'b0;
    end else begin
      crs_reg <= rx_dv_reg ||
                 (tx_act_reg && !line_full_duplex_out);
      col_reg <= !line_full_duplex_out &&
                 ((tx_act_reg && rx_dv_reg) ||
                  sqe_cnt_reg != 6'h00);
    end
  end

  assign link.crs = crs_reg;
  assign link.col = col_reg;

  ////////////////////////////////////////////////////////////////////////
  // Receive path

  // Queue of received nibbles, drained one per falling clock edge
  mps_fifo #(
    .WIDTH (RXQ_W),
    .DEPTH (RXQ_DEPTH)
  ) u_rx_queue (
    .clk_in        (clk_in),
    .reset_in      (reset_in),
    .in_valid_in   (rx_valid_in),
    .in_data_in    ({rx_code_err_in, rx_data_in}),
    .in_ready_out  (rx_ready_out),
    .out_valid_out (q_valid),
    .out_data_out  (q_data),
    .out_ready_in  (fall)
  );

  // An empty queue at a falling edge ends the packet
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rxd_reg   <= '0;
      rx_dv_reg <= 1'b0;
      rx_er_reg <= 1'b0;
    end else if (fall) begin
      rxd_reg   <= q_valid ? q_data[NIB_W-1:0] : '0;
      rx_dv_reg <= q_valid;
      rx_er_reg <= q_valid && q_data[ERR_BIT] &&
                   line_speed_100_out;
    end
  end

  assign link.rxd   = rxd_reg;
  assign link.rx_dv = rx_dv_reg;
  assign link.rx_er = rx_er_reg;

  ////////////////////////////////////////////////////////////////////////
  // Management interface

  // Management clock and data brought in through two flip-flops
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mdc_sync_reg  <= 3'h0;
      mdio_sync_reg <= 2'h3;
    end else begin
      mdc_sync_reg  <= {mdc_sync_reg[1:0], link.mdc};
      mdio_sync_reg <= {mdio_sync_reg[0], link.mdio};
    end
  end

  assign md_rise = mdc_sync_reg[1] && !mdc_sync_reg[2];
  assign md_bit  = mdio_sync_reg[1];

  // Frame decoder; every step waits for a management clock edge
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      md_state_reg     <= MD_IDLE;
      md_cnt_reg       <= 5'h00;
      md_head_reg      <= 13'h0000;
      md_shift_reg     <= '0;
      md_oe_reg        <= 1'b0;
      mgmt_addr_out    <= '0;
      mgmt_wr_out      <= 1'b0;
      mgmt_wr_data_out <= '0;
    end else begin
      mgmt_wr_out <= 1'b0;
      if (md_rise) begin
        case (md_state_reg)
          MD_IDLE: begin
            if (!md_bit) begin
              md_state_reg <= MD_HEAD;
              md_cnt_reg   <= 5'h01;
            end
          end
          MD_HEAD: begin
            md_head_reg <= {md_head_reg[11:0], md_bit};
            md_cnt_reg  <= md_cnt_reg + 5'h01;
            if (md_cnt_reg == MD_HEAD_END) begin
              md_state_reg  <= MD_TA;
              md_cnt_reg    <= 5'h00;
              mgmt_addr_out <= {md_head_reg[8:0], md_bit};
            end
          end
          MD_TA: begin
            md_cnt_reg <= md_cnt_reg + 5'h01;
            if (md_cnt_reg == 5'h00) begin
              // Head holds start bit, op code, then the address
              md_oe_reg    <= md_head_reg[11:10] == OP_RD;
              md_shift_reg <= mgmt_rd_data_in;
            end else begin
              md_state_reg <= MD_DATA;
              md_cnt_reg   <= 5'h00;
              md_oe_reg    <= md_head_reg[11:10] == OP_RD &&
                              !md_shift_reg[MD_DATA_W-1];
              md_shift_reg <= {md_shift_reg[MD_DATA_W-2:0], 1'b0};
            end
          end
          MD_DATA: begin
            md_cnt_reg       <= md_cnt_reg + 5'h01;
            mgmt_wr_data_out <= {mgmt_wr_data_out[MD_DATA_W-2:0], md_bit};
            md_oe_reg        <= md_head_reg[11:10] == OP_RD &&
                                !md_shift_reg[MD_DATA_W-1];
            md_shift_reg     <= {md_shift_reg[MD_DATA_W-2:0], 1'b0};
            if (md_cnt_reg == MD_DATA_END) begin
              md_state_reg <= MD_IDLE;
              md_oe_reg    <= 1'b0;
              mgmt_wr_out  <= md_head_reg[11:10] == OP_WR;
            end
          end
          default: begin
            md_state_reg <= MD_IDLE;
            md_oe_reg    <= 1'b0;
          end
        endcase
      end
    end
  end

  // Only ever pulls low or lets go
  assign link.mdio_phy_o  = 1'b0;
  assign link.mdio_phy_oe = md_oe_reg;
endmodule : mps_phy_end

// file: verilog/mps_pkg.sv
// Shared constants and types for the MII PHY-side link and its two ends
package mps_pkg;
  // Clock rates
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned CLK_100_HZ  = 25_000_000;
  localparam int unsigned CLK_10_HZ   = 2_500_000;
  localparam int unsigned MDC_MAX_HZ  = 25_000_000;
  localparam int unsigned MDC_HZ      = 6_250_000;
  // Half periods of the generated clocks, in cycles of clk_in
  localparam logic [4:0]  HALF_100    = 5'(CLK_HZ / (2 * CLK_100_HZ));
  localparam logic [4:0]  HALF_10     = 5'(CLK_HZ / (2 * CLK_10_HZ));
  localparam logic [2:0]  MDC_HALF    = 3'(CLK_HZ / (2 * MDC_HZ));
  // Heartbeat length after the end of a transmission
  localparam int unsigned SQE_NS      = 1000;
  localparam logic [5:0]  SQE_CYC     =
    6'((SQE_NS * (CLK_HZ / 1_000_000)) / 1000);
  // Data path widths
  localparam int          NIB_W       = 4;
  localparam int          RXQ_W       = NIB_W + 1;
  localparam int          RXQ_DEPTH   = 4;
  localparam int          ERR_BIT     = NIB_W;
  // Management frame layout
  localparam int          MD_ADDR_W   = 10;
  localparam int          MD_DATA_W   = 16;
  localparam logic [4:0]  MD_HEAD_END = 5'h0D;
  localparam logic [4:0]  MD_DATA_END = 5'h0F;
  localparam logic [5:0]  MD_LAST_BIT = 6'h3F;
  localparam logic [5:0]  MD_DATA_1ST = 6'h30;
  localparam logic [31:0] MD_PREAMBLE = 32'hFFFF_FFFF;
  localparam logic [1:0]  MD_START    = 2'h1;
  localparam logic [1:0]  OP_RD       = 2'h2;
  localparam logic [1:0]  OP_WR       = 2'h1;
  localparam logic [1:0]  TA_WR       = 2'h2;
  localparam logic [1:0]  TA_RD       = 2'h3;

  typedef enum logic [1:0] {MD_IDLE, MD_HEAD, MD_TA, MD_DATA} mps_md_state_e;
  typedef enum logic {MM_IDLE, MM_SHIFT} mps_mm_state_e;
endpackage : mps_pkg
